/* inc/mic_pkg.sv */
// constants, layouts and carriers of the interrupt control block
// What this block does
// RQ1: eleven request sources are kept, each in a flag bit of its own.
// RQ2: a flag sets on its event whatever its own enable and the global enable.
// RQ3: global_irq_enable at control bit 7 lets unmasked requests through.
// RQ4: with global enable set, any flag with its enable (and, for peripheral flags, the group enable) set is taken at the next instruction boundary.
// RQ5: every reset clears the global enable.
// RQ6: taking a request clears global enable, pushes the return address, vectors.
// RQ7: return_from_irq leaves the handler and sets the global enable again.
// RQ8: peripheral flags and enables sit in two pairs, gated by a group enable.
// RQ9: pin and port-change requests reach the core in three or four cycles.
// RQ10: the external pin sets its flag at bit 1 on the edge chosen by the option.
// RQ11: clearing ext_pin_enable masks the pin request but the flag still sets.
// RQ12: an enabled pin request wakes from sleep; vectoring needs global enable.
// RQ13: timer zero wrapping from all ones to zero sets bit 2, enabled by bit 5.
// RQ14: a change on a selected port pin sets bit 0, gated by its own enable.
// RQ15: after wake-up the vector loads only with global enable set.
// RQ16: any enabled source wakes from sleep regardless of the global enable.
// RQ17: the core request is global enable and the OR of all enabled sources.
package mic_pkg;

  // ----------------------------------------------------------------
  // register map (word index on the plain port)
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 4;
  localparam logic [3:0]  OFS_CONTROL     = 4'h0;
  localparam logic [3:0]  OFS_OPTION      = 4'h1;
  localparam logic [3:0]  OFS_CHANGE_SEL  = 4'h2;
  localparam logic [3:0]  OFS_PFLAG_FIRST = 4'h3;
  localparam logic [3:0]  OFS_PFLAG_SEC   = 4'h4;
  localparam logic [3:0]  OFS_PEN_FIRST   = 4'h5;
  localparam logic [3:0]  OFS_PEN_SEC     = 4'h6;
  localparam logic [3:0]  OFS_EVT_STATUS  = 4'h7;
  localparam logic [3:0]  OFS_EVT_MASK    = 4'h8;

  // ----------------------------------------------------------------
  // control register fields, option edge bit
  // ----------------------------------------------------------------
  localparam int BIT_GIE    = 7;
  localparam int BIT_PEIE   = 6;
  localparam int BIT_TIMER_ZERO_OVERFLOW_ENABLE   = 5;
  localparam int BIT_EXTIE  = 4;
  localparam int BIT_CHGIE  = 3;
  localparam int BIT_TIMER_ZERO_OVERFLOW_FLAG   = 2;
  localparam int BIT_EXTIF  = 1;
  localparam int BIT_CHGIF  = 0;
  localparam int BIT_EDGE   = 6;

  // ----------------------------------------------------------------
  // reset values, vector, event bits
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_CONTROL    = 8'h00;
  localparam logic [7:0]  RST_OPTION     = 8'hFF;
  localparam logic [7:0]  RST_CHANGE_SEL = 8'hF0;
  localparam logic [12:0] IRQ_VECTOR     = 13'h0004;
  localparam logic [7:0]  TMR_ALL_ONES   = 8'hFF;
  localparam logic [7:0]  TMR_ZERO       = 8'h00;
  localparam int          EVT_W          = 3;
  localparam int          EVT_TAKEN      = 0;
  localparam int          EVT_WAKE       = 1;
  localparam int          EVT_RETURN     = 2;

  typedef enum logic [0:0] { ST_RUN, ST_SLEEP } mic_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } mic_bus_t;

  typedef struct packed {
    logic        instr_done;
    logic        return_from_irq;
    logic        sleep_enter;
    logic [12:0] next_pc;
  } mic_core_t;

endpackage : mic_pkg

/* sim/mic_core_model.sv */
// behavioural core sequencer facing the interrupt control block
`timescale 1ns/1ps
module mic_core_model (
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire logic          slow,
  input  wire logic          do_ret,
  input  wire logic          do_sleep,
  input  wire logic          vector_load,
  input  wire logic [12:0]   vector_addr,
  input  wire logic          sleeping,
  output mic_pkg::mic_core_t core
);
  logic [12:0] pc_q;
  logic        half_q;

  // slow mode stretches every instruction to two cycles
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_q   <= 13'h0000;
      half_q <= 1'b0;
    end else if (vector_load) begin
      pc_q   <= vector_addr;
      half_q <= 1'b0;
    end else if (!sleeping) begin
      half_q <= slow && !half_q;
      if (core.instr_done) pc_q <= pc_q + 13'h0001;
    end
  end

  // no instruction boundary while asleep: the clock is stopped
  always_comb begin
    core.instr_done      = arst_n && !sleeping && (!slow || half_q);
    core.return_from_irq = do_ret;
    core.sleep_enter     = do_sleep;
    core.next_pc         = pc_q + 13'h0001;
  end
endmodule : mic_core_model

/* sim/mic_irq_ctrl_chk.sv */
// port assertions for the interrupt control block
`timescale 1ns/1ps
module mic_irq_ctrl_chk (
  input wire logic               clk,
  input wire logic               arst_n,
  input wire mic_pkg::mic_core_t core,
  input wire logic               irq_req,
  input wire logic               vector_load,
  input wire logic [12:0]        vector_addr,
  input wire logic               stack_push,
  input wire logic [12:0]        stack_push_addr,
  input wire logic               wake,
  input wire logic               sleeping,
  input wire logic               sleep_as_nop
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // ----------------------------------------------------------------
  // vectoring
  // ----------------------------------------------------------------
  take_vec_a: assert property (
    (irq_req && core.instr_done && !sleeping) |=> vector_load ##1 !vector_load)
    else $error("request taken without a one cycle vector load");
  push_addr_a: assert property (
    (irq_req && core.instr_done && !sleeping)
      |=> stack_push_addr == $past(core.next_pc))
    else $error("pushed return address is not the core address");
  vec_pair_a: assert property (
    vector_load |-> stack_push && vector_addr == 13'h0004)
    else $error("vector load without push or at a wrong address");
  req_drop_a: assert property (
    vector_load |-> !irq_req)
    else $error("request still up after it was taken");
  vec_hold_a: assert property (
    ($changed(vector_addr) || $changed(stack_push_addr)) |-> vector_load)
    else $error("vector or push address moved outside a take");

  // ----------------------------------------------------------------
  // sleep and wake-up
  // ----------------------------------------------------------------
  wake_exit_a: assert property (
    wake |-> !sleeping && $past(sleeping))
    else $error("wake pulse without leaving sleep");
  sleep_fall_a: assert property (
    $fell(sleeping) |-> wake)
    else $error("sleep left without a wake pulse");
  sleep_nop_a: assert property (
    sleep_as_nop |-> $past(core.sleep_enter) && !sleeping)
    else $error("sleep treated as no-op wrongly");
  sleep_in_a: assert property (
    (core.sleep_enter && !sleeping) |=> (sleeping ^ sleep_as_nop))
    else $error("sleep instruction neither slept nor skipped");
endmodule : mic_irq_ctrl_chk

bind mic_irq_ctrl mic_irq_ctrl_chk chk_u (
  .clk(clk), .arst_n(arst_n), .core(core), .irq_req(irq_req),
  .vector_load(vector_load), .vector_addr(vector_addr),
  .stack_push(stack_push), .stack_push_addr(stack_push_addr),
  .wake(wake), .sleeping(sleeping), .sleep_as_nop(sleep_as_nop)
);

/* sim/mic_irq_ctrl_tb.sv */
// self-checking bench for the interrupt control block
`timescale 1ns/1ps
module mic_irq_ctrl_tb;
  typedef struct packed {
    logic [7:0] opt;
    logic [7:0] ctl;
    logic [2:0] kind;
    logic [7:0] val;
    logic [3:0] ra;
    logic [7:0] exp;
  } mic_row_t;

  logic               clk = 1'b0;
  logic               arst_n = 1'b0;
  mic_pkg::mic_bus_t  bus = '0;
  mic_pkg::mic_core_t core;
  logic [7:0]         rdata;
  logic               ext_irq_pin = 1'b0;
  logic [7:0]         timer_zero_count = 8'h00;
  logic [7:0]         second_io_port = 8'h00;
  logic [6:0]         periph_event_first = 7'h00;
  logic [0:0]         periph_event_second = 1'b0;
  logic               slow = 1'b0;
  logic               do_ret = 1'b0;
  logic               do_sleep = 1'b0;
  logic               irq_req, vector_load, stack_push, wake;
  logic               sleeping, sleep_as_nop, irq_out;
  logic [12:0]        vector_addr, stack_push_addr;
  int                 num_errors = 0;
  int                 num_checks = 0;
  int                 n;
  mic_row_t           rows [10];

  always #2 clk = ~clk;

  mic_irq_ctrl #(.PF1_W(7), .PF2_W(1)) dut_u (
    .clk(clk), .arst_n(arst_n), .bus(bus), .rdata(rdata), .core(core),
    .ext_irq_pin(ext_irq_pin), .timer_zero_count(timer_zero_count),
    .second_io_port(second_io_port),
    .periph_event_first(periph_event_first),
    .periph_event_second(periph_event_second), .irq_req(irq_req),
    .vector_load(vector_load), .vector_addr(vector_addr),
    .stack_push(stack_push), .stack_push_addr(stack_push_addr),
    .wake(wake), .sleeping(sleeping), .sleep_as_nop(sleep_as_nop),
    .irq_out(irq_out));

  mic_core_model mdl_u (
    .clk(clk), .arst_n(arst_n), .slow(slow), .do_ret(do_ret),
    .do_sleep(do_sleep), .vector_load(vector_load),
    .vector_addr(vector_addr), .sleeping(sleeping), .core(core));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) bus <= '0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk) bus <= '0;
    #1 check(rdata === e, "register read");
  endtask : rd

  // sel 1 waits for wake, 0 for a vector load; gives up after 10
  task automatic wait_on(input logic sel, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk);
      #1 cnt++;
    end while ((sel ? wake : vector_load) !== 1'b1 && cnt < 10);
  endtask : wait_on

  task automatic pulse(input logic sleep_not_ret);
    @(posedge clk) if (sleep_not_ret) do_sleep <= 1'b1; else do_ret <= 1'b1;
    @(posedge clk) if (sleep_not_ret) do_sleep <= 1'b0; else do_ret <= 1'b0;
  endtask : pulse

  task automatic reset_chk;
    @(posedge clk) arst_n <= 1'b0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(4'h0, 8'h00);
    rd(4'h1, 8'hFF);
    rd(4'h2, 8'hF0);
    rd(4'hF, 8'h00);
    $display("reset test done");
  endtask : reset_chk

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  // kinds: 0 pin level, 1 timer step, 2 port, 3/4 peripheral pulse
  initial begin
    rows = '{'{8'hFF, 8'h00, 3'd0, 8'h01, 4'h0, 8'h02},
             '{8'hFF, 8'h00, 3'd0, 8'h00, 4'h0, 8'h00},
             '{8'hBF, 8'h00, 3'd0, 8'h01, 4'h0, 8'h00},
             '{8'hBF, 8'h10, 3'd0, 8'h00, 4'h0, 8'h12},
             '{8'hFF, 8'h20, 3'd1, 8'h00, 4'h0, 8'h24},
             '{8'hFF, 8'h00, 3'd1, 8'hFF, 4'h0, 8'h00},
             '{8'hFF, 8'h08, 3'd2, 8'h10, 4'h0, 8'h09},
             '{8'hFF, 8'h00, 3'd2, 8'h11, 4'h0, 8'h00},
             '{8'hFF, 8'h40, 3'd3, 8'h40, 4'h3, 8'h40},
             '{8'hFF, 8'h00, 3'd4, 8'h01, 4'h4, 8'h01}};
    reset_chk();
    foreach (rows[i]) begin
      wr(4'h1, rows[i].opt);
      wr(rows[i].ra, 8'h00);
      wr(4'h0, rows[i].ctl);
      @(posedge clk) case (rows[i].kind)
        3'd0: ext_irq_pin <= rows[i].val[0];
        3'd1: timer_zero_count <= rows[i].val - 8'h01;
        3'd2: second_io_port <= rows[i].val;
        3'd3: periph_event_first <= rows[i].val[6:0];
        default: periph_event_second <= rows[i].val[0:0];
      endcase
      @(posedge clk) begin
        if (rows[i].kind == 3'd1) timer_zero_count <= rows[i].val;
        periph_event_first <= 7'h00;
        periph_event_second <= 1'b0;
      end
      repeat (3) @(posedge clk);
      rd(rows[i].ra, rows[i].exp);
      check(irq_req === 1'b0, "request with global enable clear");
    end
    $display("flag table done");
    // prompt core first, then a core with two-cycle instructions
    for (int s = 0; s < 2; s++) begin
      @(posedge clk) begin
        ext_irq_pin <= 1'b0;
        slow <= s[0];
      end
      wr(4'h0, 8'h90);
      @(posedge clk) ext_irq_pin <= 1'b1;
      wait_on(1'b0, n);
      check(n == 3 || n == 4, "pin latency");
      check(vector_addr === 13'h0004, "vector");
      rd(4'h0, 8'h12);
      wr(4'h0, 8'h10);
      pulse(1'b0);
      rd(4'h0, 8'h90);
      wr(4'h0, 8'h00);
    end
    $display("take test done");
    wr(4'h5, 8'h01);
    wr(4'h0, 8'h80);
    @(posedge clk) periph_event_first <= 7'h01;
    @(posedge clk) periph_event_first <= 7'h00;
    repeat (4) @(posedge clk);
    #1 check(irq_req === 1'b0, "group enable ignored");
    wr(4'h0, 8'hC0);
    wait_on(1'b0, n);
    check(n < 10, "peripheral request not taken");
    wr(4'h3, 8'h00);
    wr(4'h5, 8'h00);
    $display("group test done");
    // wake with global enable clear, then set
    for (int g = 0; g < 2; g++) begin
      @(posedge clk) ext_irq_pin <= 1'b0;
      wr(4'h0, g ? 8'h90 : 8'h10);
      pulse(1'b1);
      #1 check(sleeping === 1'b1, "sleep not entered");
      @(posedge clk) ext_irq_pin <= 1'b1;
      wait_on(1'b1, n);
      check(n < 10 && sleeping === 1'b0, "no wake");
      wait_on(1'b0, n);
      check((n < 10) == (g == 1), "vectoring after wake");
    end
    pulse(1'b1);
    #1 check(sleep_as_nop === 1'b1 && sleeping === 1'b0, "nop");
    $display("sleep test done");
    check(irq_out === 1'b0, "line up while masked");
    rd(4'h7, 8'h07);
    wr(4'h8, 8'h02);
    repeat (2) @(posedge clk);
    #1 check(irq_out === 1'b1, "line not raised");
    wr(4'h7, 8'h07);
    repeat (2) @(posedge clk);
    #1 check(irq_out === 1'b0, "line not cleared");
    rd(4'h7, 8'h00);
    $display("line test done");
    wr(4'h0, 8'h80);
    reset_chk();
    give_verdict();
  end

  // the sequence needs well under 1000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
endmodule : mic_irq_ctrl_tb

/* src/mic_irq_ctrl.sv */
// interrupt control logic: flags, enables, vectoring and sleep wake-up
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module mic_irq_ctrl #(
  parameter int PF1_W = 7,
  parameter int PF2_W = 1
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire mic_pkg::mic_bus_t bus,
  output logic [7:0]             rdata,
  input  wire mic_pkg::mic_core_t core,
  input  wire logic              ext_irq_pin,
  input  wire logic [7:0]        timer_zero_count,
  input  wire logic [7:0]        second_io_port,
  input  wire logic [PF1_W-1:0]  periph_event_first,
  input  wire logic [PF2_W-1:0]  periph_event_second,
  output logic                   irq_req,
  output logic                   vector_load,
  output logic [12:0]            vector_addr,
  output logic                   stack_push,
  output logic [12:0]            stack_push_addr,
  output logic                   wake,
  output logic                   sleeping,
  output logic                   sleep_as_nop,
  output logic                   irq_out
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_s1_q;
  logic rst_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic wr_hit(input mic_pkg::mic_bus_t b,
                                  input logic [3:0] ofs);
    wr_hit = b.wr && (b.addr == ofs);
  endfunction : wr_hit

  // software may write a flag either way; a same-cycle event still wins
  function automatic logic flag_next(input logic q, input logic hit,
                                     input logic wbit, input logic ev);
    flag_next = (hit ? wbit : q) | ev;
  endfunction : flag_next

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // eleven sources: three core flags plus PF1_W + PF2_W peripheral flags
  logic [7:0]       control_q;                                   // [RQ1]
  logic [7:0]       option_q;
  logic [7:0]       change_sel_q;
  logic [PF1_W-1:0] pflag1_q;
  logic [PF2_W-1:0] pflag2_q;
  logic [PF1_W-1:0] pen1_q;
  logic [PF2_W-1:0] pen2_q;
  logic [mic_pkg::EVT_W-1:0] evt_status_q;
  logic [mic_pkg::EVT_W-1:0] evt_mask_q;
  mic_pkg::mic_state_t       state_q;

  // ----------------------------------------------------------------
  // edge detector priming
  // ----------------------------------------------------------------
  // history regs hold reset zeros on the first cycle, not the pin
  // levels; a pin left high over a reset must not read as an edge
  logic primed_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      primed_q <= 1'b0;
    end else begin
      primed_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // source event detection
  // ----------------------------------------------------------------
  logic       ext_pin_q;
  logic [7:0] tmr_prev_q;
  logic [7:0] port_prev_q;
  logic       ext_rise;
  logic       ext_fall;
  logic       ext_edge_ev;
  logic       tmr_ovf_ev;
  logic       chg_ev;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_pin_q   <= 1'b0;
      tmr_prev_q  <= 8'h00;
      port_prev_q <= 8'h00;
    end else begin
      ext_pin_q   <= ext_irq_pin;
      tmr_prev_q  <= timer_zero_count;
      port_prev_q <= second_io_port;
    end
  end

  // events are held off until the history regs have sampled once
  assign ext_rise    = primed_q & ext_irq_pin & ~ext_pin_q;
  assign ext_fall    = primed_q & ~ext_irq_pin & ext_pin_q;
  assign ext_edge_ev = option_q[mic_pkg::BIT_EDGE] ? ext_rise
                                                   : ext_fall;  // [RQ10]
  assign tmr_ovf_ev  = primed_q &&
                       (tmr_prev_q == mic_pkg::TMR_ALL_ONES) &&
                       (timer_zero_count == mic_pkg::TMR_ZERO);  // [RQ13]
  assign chg_ev      = primed_q &
                       (|((second_io_port ^ port_prev_q) &
                          change_sel_q));                        // [RQ14]

  // ----------------------------------------------------------------
  // request combination
  // ----------------------------------------------------------------
  logic core_src;
  logic periph_src;
  logic any_src;
  logic take;
  logic global_irq_enable;

  assign global_irq_enable        = control_q[mic_pkg::BIT_GIE];
  assign core_src   =
      (control_q[mic_pkg::BIT_EXTIF] & control_q[mic_pkg::BIT_EXTIE]) |  // [RQ11]
      (control_q[mic_pkg::BIT_TIMER_ZERO_OVERFLOW_FLAG]  & control_q[mic_pkg::BIT_TIMER_ZERO_OVERFLOW_ENABLE])  |  // [RQ13]
      (control_q[mic_pkg::BIT_CHGIF] & control_q[mic_pkg::BIT_CHGIE]);   // [RQ14]
  assign periph_src = control_q[mic_pkg::BIT_PEIE] &
                      (|(pflag1_q & pen1_q) | |(pflag2_q & pen2_q));     // [RQ8]
  assign any_src    = core_src | periph_src;
  // taken at the next instruction boundary, so two-cycle instructions
  // can see one cycle more latency from the registered request than one-cycle ones
  assign take       = irq_req && core.instr_done &&
                      (state_q == mic_pkg::ST_RUN);              // [RQ4] [RQ9]

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic       ctl_hit;
  logic [7:0] ctl_d;

  assign ctl_hit = wr_hit(bus, mic_pkg::OFS_CONTROL);

  always_comb begin
    ctl_d = ctl_hit ? bus.wdata : control_q;
    ctl_d[mic_pkg::BIT_EXTIF] = flag_next(control_q[mic_pkg::BIT_EXTIF],
        ctl_hit, bus.wdata[mic_pkg::BIT_EXTIF], ext_edge_ev);    // [RQ2] [RQ10]
    ctl_d[mic_pkg::BIT_TIMER_ZERO_OVERFLOW_FLAG]  = flag_next(control_q[mic_pkg::BIT_TIMER_ZERO_OVERFLOW_FLAG],
        ctl_hit, bus.wdata[mic_pkg::BIT_TIMER_ZERO_OVERFLOW_FLAG], tmr_ovf_ev);      // [RQ2] [RQ13]
    ctl_d[mic_pkg::BIT_CHGIF] = flag_next(control_q[mic_pkg::BIT_CHGIF],
        ctl_hit, bus.wdata[mic_pkg::BIT_CHGIF], chg_ev);         // [RQ2] [RQ14]
    // accepting a request outranks software and the return instruction
    if (take) begin
      ctl_d[mic_pkg::BIT_GIE] = 1'b0;                            // [RQ6]
    end else if (core.return_from_irq) begin
      ctl_d[mic_pkg::BIT_GIE] = 1'b1;                            // [RQ7]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      control_q <= mic_pkg::RST_CONTROL;                         // [RQ5]
    end else begin
      control_q <= ctl_d;
    end
  end

  // ----------------------------------------------------------------
  // option and pin select
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      option_q     <= mic_pkg::RST_OPTION;
      change_sel_q <= mic_pkg::RST_CHANGE_SEL;
    end else begin
      if (wr_hit(bus, mic_pkg::OFS_OPTION)) begin
        option_q <= bus.wdata;
      end
      if (wr_hit(bus, mic_pkg::OFS_CHANGE_SEL)) begin
        change_sel_q <= bus.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // peripheral flags and enables
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pflag1_q <= '0;
      pflag2_q <= '0;
    end else begin
      for (int i = 0; i < PF1_W; i++) begin
        pflag1_q[i] <= flag_next(pflag1_q[i],
            wr_hit(bus, mic_pkg::OFS_PFLAG_FIRST), bus.wdata[i],
            periph_event_first[i]);                              // [RQ2] [RQ8]
      end
      for (int j = 0; j < PF2_W; j++) begin
        pflag2_q[j] <= flag_next(pflag2_q[j],
            wr_hit(bus, mic_pkg::OFS_PFLAG_SEC), bus.wdata[j],
            periph_event_second[j]);                             // [RQ2] [RQ8]
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pen1_q <= '0;
      pen2_q <= '0;
    end else begin
      if (wr_hit(bus, mic_pkg::OFS_PEN_FIRST)) begin
        pen1_q <= bus.wdata[PF1_W-1:0];
      end
      if (wr_hit(bus, mic_pkg::OFS_PEN_SEC)) begin
        pen2_q <= bus.wdata[PF2_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // core request and vectoring
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_req <= 1'b0;
    end else begin
      // dropped in the cycle of the take so it cannot fire twice
      irq_req <= global_irq_enable && any_src && !take;                        // [RQ3] [RQ17]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vector_load     <= 1'b0;
      vector_addr     <= 13'h0000;
      stack_push      <= 1'b0;
      stack_push_addr <= 13'h0000;
    end else begin
      vector_load <= take;                                       // [RQ6]
      stack_push  <= take;                                       // [RQ6]
      if (take) begin
        vector_addr     <= mic_pkg::IRQ_VECTOR;                  // [RQ6] [RQ15]
        stack_push_addr <= core.next_pc;                         // [RQ6]
      end
    end
  end

  // ----------------------------------------------------------------
  // sleep and wake-up
  // ----------------------------------------------------------------
  logic wake_ev;
  logic nop_ev;

  // wake ignores the global enable; the later take needs it
  assign wake_ev = (state_q == mic_pkg::ST_SLEEP) && any_src;   // [RQ12] [RQ16]
  // a request already pending turns the sleep instruction into a no-op
  assign nop_ev  = (state_q == mic_pkg::ST_RUN) && core.sleep_enter &&
                   any_src;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= mic_pkg::ST_RUN;
    end else begin
      case (state_q)
        mic_pkg::ST_RUN: begin
          if (core.sleep_enter && !any_src) begin
            state_q <= mic_pkg::ST_SLEEP;
          end
        end
        mic_pkg::ST_SLEEP: begin
          if (any_src) begin
            state_q <= mic_pkg::ST_RUN;                          // [RQ15]
          end
        end
        default: begin
          state_q <= mic_pkg::ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake         <= 1'b0;
      sleeping     <= 1'b0;
      sleep_as_nop <= 1'b0;
    end else begin
      wake         <= wake_ev;                                   // [RQ12]
      sleeping     <= (state_q == mic_pkg::ST_RUN) ?
                      (core.sleep_enter && !any_src) : !any_src;
      sleep_as_nop <= nop_ev;
    end
  end

  // ----------------------------------------------------------------
  // block event status, mask and interrupt line
  // ----------------------------------------------------------------
  logic [mic_pkg::EVT_W-1:0] evt_set;
  logic [mic_pkg::EVT_W-1:0] evt_clr;

  always_comb begin
    evt_set = '0;
    evt_set[mic_pkg::EVT_TAKEN]  = take;
    evt_set[mic_pkg::EVT_WAKE]   = wake_ev;
    evt_set[mic_pkg::EVT_RETURN] = core.return_from_irq;
    evt_clr = wr_hit(bus, mic_pkg::OFS_EVT_STATUS) ?
              bus.wdata[mic_pkg::EVT_W-1:0] : '0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_status_q <= '0;
      evt_mask_q   <= '0;
      irq_out      <= 1'b0;
    end else begin
      // set beats a write-one-to-clear in the same cycle
      evt_status_q <= (evt_status_q & ~evt_clr) | evt_set;
      if (wr_hit(bus, mic_pkg::OFS_EVT_MASK)) begin
        evt_mask_q <= bus.wdata[mic_pkg::EVT_W-1:0];
      end
      irq_out <= |(((evt_status_q & ~evt_clr) | evt_set) &
                   (wr_hit(bus, mic_pkg::OFS_EVT_MASK) ?
                    bus.wdata[mic_pkg::EVT_W-1:0] : evt_mask_q));
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        mic_pkg::OFS_CONTROL:     rdata <= control_q;
        mic_pkg::OFS_OPTION:      rdata <= option_q;
        mic_pkg::OFS_CHANGE_SEL:  rdata <= change_sel_q;
        mic_pkg::OFS_PFLAG_FIRST: rdata <= 8'(pflag1_q);
        mic_pkg::OFS_PFLAG_SEC:   rdata <= 8'(pflag2_q);
        mic_pkg::OFS_PEN_FIRST:   rdata <= 8'(pen1_q);
        mic_pkg::OFS_PEN_SEC:     rdata <= 8'(pen2_q);
        mic_pkg::OFS_EVT_STATUS:  rdata <= 8'(evt_status_q);
        mic_pkg::OFS_EVT_MASK:    rdata <= 8'(evt_mask_q);
        default:                  rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule : mic_irq_ctrl
